// File: logic/lpmc_pkg.sv
// Constants, mode encoding and helpers for the low power mode controller
package lpmc_pkg;

  // ==========================================================================
  // Register map (byte addresses, 32-bit words)
  // ==========================================================================
  localparam int         LPMC_ADDR_W    = 8;
  localparam logic [7:0] LPMC_OFS_CTRL  = 8'h00;
  localparam logic [7:0] LPMC_OFS_MSTOP = 8'h04;
  localparam logic [7:0] LPMC_OFS_MRET  = 8'h08;
  localparam logic [7:0] LPMC_OFS_STAT  = 8'h0c;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int LPMC_CTRL_STANDBY_SELECT_BIT    = 0;
  localparam int LPMC_CTRL_DIRECT_TRANSITION_ON_BIT    = 1;
  localparam int LPMC_CTRL_LOW_SPEED_ON_BIT    = 2;
  localparam int LPMC_CTRL_PSS     = 3;
  localparam int LPMC_CTRL_SCK_LSB = 4;
  localparam int LPMC_SCK_W        = 3;
  localparam int LPMC_STAT_RST_PIN = 8;
  localparam int LPMC_STAT_STB_PIN = 9;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [31:0] LPMC_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] LPMC_MSTOP_RST = 32'h0000_0000;
  localparam logic [31:0] LPMC_MRET_RST  = 32'h0000_0000;
  localparam logic [2:0]  LPMC_SYNC_RST  = 3'h7;

  // Peripheral lanes that keep running on the subclock
  localparam int LPMC_PER_TMR0 = 0;
  localparam int LPMC_PER_TMR1 = 1;
  localparam int LPMC_PER_WDT0 = 2;
  localparam int LPMC_PER_WDT1 = 3;
  localparam int LPMC_NPER     = 8;

  localparam logic [1:0] LPMC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] LPMC_RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    LPMC_HIGH_SPEED = 5'h01,
    LPMC_SUB_ACTIVE = 5'h02,
    LPMC_WATCH      = 5'h04,
    LPMC_SUB_SLEEP  = 5'h08,
    LPMC_HW_STANDBY = 5'h10
  } lpmc_mode_t;

  function automatic logic [31:0] lpmc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
        res[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return res;
  endfunction : lpmc_merge

endpackage : lpmc_pkg

// File: logic/lpmc_ctrl.sv
// Power mode sequencer with AXI4-Lite control registers
//
// Overview of operation
// - Sleep in high speed with all bits enters subactive
// - Watch plus interrupt with low-speed-on enters subactive
// - Subsleep plus interrupt returns to subactive
// - Subactive: CPU on subclock, only timers/watchdogs run
// - Subactive left by sleep, reset or standby pin
// - Subactive sleep, select 1, direct 0: watch
// - Subactive sleep, select 0, low-speed 1: subsleep
// - Subactive sleep, select 1, pair 10: high speed
// - Reset pin low starts and supplies system clock
// - Reset held until settled; release starts reset exception
// - Standby pin low forces hardware standby always
// - Module stop halts only selected peripherals
// - Halt with reset clears; with retention keeps, except in hardware standby or with the reset pin held
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module lpmc_ctrl
  import lpmc_pkg::*;
#(
  parameter int NP = lpmc_pkg::LPMC_NPER
)(
  input  wire logic                           sys_clk_i,          // 40 MHz system clock
  input  wire logic                           resetn_i,           // Async reset, active low
  input  wire logic                           sleep_req_i,        // Sleep instruction pulse
  input  wire logic                           wake_irq_i,         // Wake interrupt pulse
  input  wire logic                           reset_pin_n_i,      // Reset pin, async
  input  wire logic                           hardware_standby_pin_n_i, // Standby pin, async
  output logic [4:0]                          mode_o,             // One-hot power mode
  output logic                                sys_clk_run_o,      // System clock oscillating and supplied
  output logic                                cpu_subclock_o,     // CPU runs from subclock
  output logic                                cpu_halt_o,         // CPU halted
  output logic                                reset_exception_o,  // Reset exception start pulse
  output logic [NP-1:0]                       periph_stop_o,      // Peripheral halt
  output logic [NP-1:0]                       periph_reset_o,     // Peripheral state reset
  input  wire logic [lpmc_pkg::LPMC_ADDR_W-1:0] s_axi_awaddr_i,   // Write address
  input  wire logic                           s_axi_awvalid_i,    // Write address valid
  output logic                                s_axi_awready_o,    // Write address ready
  input  wire logic [31:0]                    s_axi_wdata_i,      // Write data
  input  wire logic [3:0]                     s_axi_wstrb_i,      // Write strobes
  input  wire logic                           s_axi_wvalid_i,     // Write data valid
  output logic                                s_axi_wready_o,     // Write data ready
  output logic [1:0]                          s_axi_bresp_o,      // Write response
  output logic                                s_axi_bvalid_o,     // Write response valid
  input  wire logic                           s_axi_bready_i,     // Write response ready
  input  wire logic [lpmc_pkg::LPMC_ADDR_W-1:0] s_axi_araddr_i,   // Read address
  input  wire logic                           s_axi_arvalid_i,    // Read address valid
  output logic                                s_axi_arready_o,    // Read address ready
  output logic [31:0]                         s_axi_rdata_o,      // Read data
  output logic [1:0]                          s_axi_rresp_o,      // Read response
  output logic                                s_axi_rvalid_o,     // Read data valid
  input  wire logic                           s_axi_rready_i      // Read data ready
);
  import lpmc_pkg::*;

  // ==========================================================================
  // State
  // ==========================================================================
  localparam logic [NP-1:0] KEEP_MASK = NP'((32'h1 << LPMC_PER_TMR0) | (32'h1 << LPMC_PER_TMR1)
                                          | (32'h1 << LPMC_PER_WDT0) | (32'h1 << LPMC_PER_WDT1));

  typedef struct packed {
    lpmc_mode_t      mode;
    logic            standby_select_bit;
    logic            direct_transition_on_bit;
    logic            low_speed_on_bit;
    logic            prescaler_select_bit;
    logic [2:0]      sck;
    logic [NP-1:0]   mstop;
    logic [NP-1:0]   mret;
    logic [2:0]      rst_s;
    logic [2:0]      stb_s;
    logic            rst_f;
    logic            stb_f;
    logic            exc;
    logic [NP-1:0]   pstop;
    logic [NP-1:0]   prst;
    logic            clk_run;
    logic            cpu_sub;
    logic            cpu_halt;
    logic            awrdy;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            arrdy;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } lpmc_state_t;

  lpmc_state_t st_r;
  lpmc_state_t st_nxt;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb
  begin
    logic [31:0] ctrl_w;
    logic [31:0] merged;
    ctrl_w = 32'h0;
    merged = 32'h0;
    st_nxt = st_r;
    st_nxt.exc = 1'b0;

    // Pins: a level counts once second and third stage agree
    st_nxt.rst_s = {st_r.rst_s[1:0], reset_pin_n_i};
    st_nxt.stb_s = {st_r.stb_s[1:0], hardware_standby_pin_n_i};
    if (st_r.rst_s[1] == st_r.rst_s[2])
      st_nxt.rst_f = st_r.rst_s[2];
    if (st_r.stb_s[1] == st_r.stb_s[2])
      st_nxt.stb_f = st_r.stb_s[2];

    // Mode sequencing
    if (!st_nxt.stb_f)
      st_nxt.mode = LPMC_HW_STANDBY;
    else if (!st_nxt.rst_f)
      st_nxt.mode = LPMC_HIGH_SPEED;
    else
    begin
      case (st_r.mode)
        LPMC_HIGH_SPEED:
          if (sleep_req_i && st_r.standby_select_bit && st_r.direct_transition_on_bit && st_r.low_speed_on_bit && st_r.prescaler_select_bit)
            st_nxt.mode = LPMC_SUB_ACTIVE;
        LPMC_SUB_ACTIVE:
          if (sleep_req_i && st_r.prescaler_select_bit)
          begin
            if (st_r.standby_select_bit && !st_r.direct_transition_on_bit)
              st_nxt.mode = LPMC_WATCH;
            else if (!st_r.standby_select_bit && st_r.low_speed_on_bit)
              st_nxt.mode = LPMC_SUB_SLEEP;
            else if (st_r.standby_select_bit && st_r.direct_transition_on_bit && !st_r.low_speed_on_bit)
              st_nxt.mode = LPMC_HIGH_SPEED;
          end
        LPMC_WATCH:
          if (wake_irq_i)
            st_nxt.mode = st_r.low_speed_on_bit ? LPMC_SUB_ACTIVE : LPMC_HIGH_SPEED;
        LPMC_SUB_SLEEP:
          if (wake_irq_i)
            st_nxt.mode = LPMC_SUB_ACTIVE;
        // Standby is left only through the reset pin
        LPMC_HW_STANDBY:
          st_nxt.mode = LPMC_HW_STANDBY;
        default:
          st_nxt.mode = LPMC_HIGH_SPEED;
      endcase
    end
    // Release of the reset pin starts the CPU reset sequence
    st_nxt.exc = st_nxt.rst_f && !st_r.rst_f && st_nxt.stb_f;

    // Register bus: write
    st_nxt.awrdy = 1'b0;
    if (st_r.bvalid && s_axi_bready_i)
      st_nxt.bvalid = 1'b0;
    if (st_r.awrdy && s_axi_awvalid_i && s_axi_wvalid_i)
    begin
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = LPMC_RESP_OKAY;
      ctrl_w = {25'h0, st_r.sck, st_r.prescaler_select_bit, st_r.low_speed_on_bit, st_r.direct_transition_on_bit, st_r.standby_select_bit};
      case (s_axi_awaddr_i)
        LPMC_OFS_CTRL:
        begin
          merged = lpmc_merge(ctrl_w, s_axi_wdata_i, s_axi_wstrb_i);
          st_nxt.standby_select_bit = merged[LPMC_CTRL_STANDBY_SELECT_BIT];
          st_nxt.direct_transition_on_bit = merged[LPMC_CTRL_DIRECT_TRANSITION_ON_BIT];
          st_nxt.low_speed_on_bit = merged[LPMC_CTRL_LOW_SPEED_ON_BIT];
          st_nxt.prescaler_select_bit = merged[LPMC_CTRL_PSS];
          st_nxt.sck = merged[LPMC_CTRL_SCK_LSB +: LPMC_SCK_W];
        end
        LPMC_OFS_MSTOP:
        begin
          merged = lpmc_merge(32'(st_r.mstop), s_axi_wdata_i, s_axi_wstrb_i);
          st_nxt.mstop = merged[NP-1:0];
        end
        LPMC_OFS_MRET:
        begin
          merged = lpmc_merge(32'(st_r.mret), s_axi_wdata_i, s_axi_wstrb_i);
          st_nxt.mret = merged[NP-1:0];
        end
        LPMC_OFS_STAT:
          st_nxt.bresp = LPMC_RESP_OKAY;
        default:
          st_nxt.bresp = LPMC_RESP_SLVERR;
      endcase
    end
    else if (s_axi_awvalid_i && s_axi_wvalid_i && !st_r.bvalid && !st_r.awrdy)
      st_nxt.awrdy = 1'b1;

    // Register bus: read
    st_nxt.arrdy = 1'b0;
    if (st_r.rvalid && s_axi_rready_i)
      st_nxt.rvalid = 1'b0;
    if (st_r.arrdy && s_axi_arvalid_i)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = LPMC_RESP_OKAY;
      st_nxt.rdata = 32'h0;
      case (s_axi_araddr_i)
        LPMC_OFS_CTRL:
          st_nxt.rdata = {25'h0, st_r.sck, st_r.prescaler_select_bit, st_r.low_speed_on_bit, st_r.direct_transition_on_bit, st_r.standby_select_bit};
        LPMC_OFS_MSTOP:
          st_nxt.rdata = 32'(st_r.mstop);
        LPMC_OFS_MRET:
          st_nxt.rdata = 32'(st_r.mret);
        LPMC_OFS_STAT:
        begin
          st_nxt.rdata[4:0] = st_r.mode;
          st_nxt.rdata[LPMC_STAT_RST_PIN] = st_r.rst_f;
          st_nxt.rdata[LPMC_STAT_STB_PIN] = st_r.stb_f;
        end
        default:
          st_nxt.rresp = LPMC_RESP_SLVERR;
      endcase
    end
    else if (s_axi_arvalid_i && !st_r.rvalid && !st_r.arrdy)
      st_nxt.arrdy = 1'b1;
    // Reset pin reinitialises the control bits, bus writes included
    if (!st_nxt.rst_f || !st_nxt.stb_f)
    begin
      st_nxt.standby_select_bit = LPMC_CTRL_RST[LPMC_CTRL_STANDBY_SELECT_BIT];
      st_nxt.direct_transition_on_bit = LPMC_CTRL_RST[LPMC_CTRL_DIRECT_TRANSITION_ON_BIT];
      st_nxt.low_speed_on_bit = LPMC_CTRL_RST[LPMC_CTRL_LOW_SPEED_ON_BIT];
      st_nxt.prescaler_select_bit = LPMC_CTRL_RST[LPMC_CTRL_PSS];
      st_nxt.sck = LPMC_CTRL_RST[LPMC_CTRL_SCK_LSB +: LPMC_SCK_W];
      st_nxt.mstop = LPMC_MSTOP_RST[NP-1:0];
      st_nxt.mret = LPMC_MRET_RST[NP-1:0];
    end
    // Clock and peripheral controls follow the coming mode
    st_nxt.clk_run = (st_nxt.mode == LPMC_HIGH_SPEED);
    st_nxt.cpu_sub = (st_nxt.mode == LPMC_SUB_ACTIVE);
    st_nxt.cpu_halt = (st_nxt.mode inside {LPMC_WATCH, LPMC_SUB_SLEEP, LPMC_HW_STANDBY}) || !st_nxt.rst_f;
    // Held reset pin initialises every lane, as standby does
    case (st_nxt.rst_f ? st_nxt.mode : LPMC_HW_STANDBY)
      LPMC_HIGH_SPEED:
      begin
        st_nxt.pstop = st_nxt.mstop;
        st_nxt.prst = st_nxt.mstop & ~st_nxt.mret;
      end
      LPMC_SUB_ACTIVE, LPMC_WATCH, LPMC_SUB_SLEEP:
      begin
        st_nxt.pstop = ~KEEP_MASK | st_nxt.mstop;
        st_nxt.prst = st_nxt.pstop & ~st_nxt.mret;
      end
      default:
      begin
        st_nxt.pstop = '1;
        st_nxt.prst = '1;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge sys_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= '0;
      st_r.mode <= LPMC_HIGH_SPEED;
      st_r.rst_s <= LPMC_SYNC_RST;
      st_r.stb_s <= LPMC_SYNC_RST;
      st_r.rst_f <= 1'b1;
      st_r.stb_f <= 1'b1;
      st_r.clk_run <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign mode_o            = st_r.mode;
  assign sys_clk_run_o     = st_r.clk_run;
  assign cpu_subclock_o    = st_r.cpu_sub;
  assign cpu_halt_o        = st_r.cpu_halt;
  assign reset_exception_o = st_r.exc;
  assign periph_stop_o     = st_r.pstop;
  assign periph_reset_o    = st_r.prst;
  assign s_axi_awready_o   = st_r.awrdy;
  assign s_axi_wready_o    = st_r.awrdy;
  assign s_axi_bresp_o     = st_r.bresp;
  assign s_axi_bvalid_o    = st_r.bvalid;
  assign s_axi_arready_o   = st_r.arrdy;
  assign s_axi_rdata_o     = st_r.rdata;
  assign s_axi_rresp_o     = st_r.rresp;
  assign s_axi_rvalid_o    = st_r.rvalid;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  wire logic pins_ok = st_nxt.rst_f && st_nxt.stb_f;

  AST_HS_TO_SUBACT: assert property ((st_r.mode == LPMC_HIGH_SPEED) && sleep_req_i && pins_ok && st_r.standby_select_bit
    && st_r.direct_transition_on_bit && st_r.low_speed_on_bit && st_r.prescaler_select_bit |=> (mode_o == LPMC_SUB_ACTIVE) && cpu_subclock_o)
    else $error("subactive not entered from high speed");
  AST_WATCH_WAKE: assert property ((st_r.mode == LPMC_WATCH) && wake_irq_i && pins_ok && st_r.low_speed_on_bit
    |=> mode_o == LPMC_SUB_ACTIVE) else $error("watch wake did not reach subactive");
  AST_SSLEEP_WAKE: assert property ((st_r.mode == LPMC_SUB_SLEEP) && wake_irq_i && pins_ok
    |=> mode_o == LPMC_SUB_ACTIVE) else $error("subsleep wake did not reach subactive");
  AST_SUBACT_PERIPH: assert property ((mode_o == LPMC_SUB_ACTIVE)
    |-> ((periph_stop_o & ~KEEP_MASK) == ~KEEP_MASK) && !sys_clk_run_o && !cpu_halt_o)
    else $error("subactive peripheral or clock state wrong");
  AST_SUBACT_HOLD: assert property ((st_r.mode == LPMC_SUB_ACTIVE) && !sleep_req_i && pins_ok
    |=> mode_o == LPMC_SUB_ACTIVE) else $error("subactive left without cause");
  AST_TO_WATCH: assert property ((st_r.mode == LPMC_SUB_ACTIVE) && sleep_req_i && pins_ok && st_r.standby_select_bit
    && !st_r.direct_transition_on_bit && st_r.prescaler_select_bit |=> (mode_o == LPMC_WATCH) && cpu_halt_o) else $error("watch not entered");
  AST_TO_SSLEEP: assert property ((st_r.mode == LPMC_SUB_ACTIVE) && sleep_req_i && pins_ok && !st_r.standby_select_bit
    && st_r.low_speed_on_bit && st_r.prescaler_select_bit |=> mode_o == LPMC_SUB_SLEEP) else $error("subsleep not entered");
  AST_TO_HS: assert property ((st_r.mode == LPMC_SUB_ACTIVE) && sleep_req_i && pins_ok && st_r.standby_select_bit
    && st_r.direct_transition_on_bit && !st_r.low_speed_on_bit && st_r.prescaler_select_bit |=> (mode_o == LPMC_HIGH_SPEED) && sys_clk_run_o)
    else $error("high speed not entered");
  AST_RST_CLK: assert property ($fell(st_r.rst_f) && st_r.stb_f |-> sys_clk_run_o && cpu_halt_o
    && (mode_o == LPMC_HIGH_SPEED)) else $error("reset pin did not start system clock");
  AST_RST_EXC: assert property ($rose(st_r.rst_f) && st_r.stb_f |-> reset_exception_o ##1 !reset_exception_o)
    else $error("reset exception pulse wrong");
  AST_HARDWARE_STANDBY_PIN_N: assert property ($fell(hardware_standby_pin_n_i) ##1 !hardware_standby_pin_n_i [*3]
    |=> mode_o == LPMC_HW_STANDBY) else $error("standby pin ignored");
  AST_MSTOP: assert property ((mode_o == LPMC_HIGH_SPEED) && st_r.rst_f |-> periph_stop_o == st_r.mstop)
    else $error("module stop mismatch");
  AST_RST_RET: assert property (st_r.rst_f && (mode_o != LPMC_HW_STANDBY)
    |-> periph_reset_o == (periph_stop_o & ~st_r.mret)) else $error("retain or reset choice wrong");
  AST_DEFAULT_HS: assert property ($rose(resetn_i) |-> mode_o == LPMC_HIGH_SPEED)
    else $error("mode after reset not high speed");

  COV_SUBACT: cover property (st_r.mode == LPMC_HIGH_SPEED ##1 st_r.mode == LPMC_SUB_ACTIVE);
  COV_WATCH_WAKE: cover property (st_r.mode == LPMC_WATCH ##1 st_r.mode == LPMC_SUB_ACTIVE);
  COV_SSLEEP: cover property (st_r.mode == LPMC_SUB_SLEEP ##1 st_r.mode == LPMC_SUB_ACTIVE);
  COV_HARDWARE_STANDBY_PIN_N: cover property (st_r.mode == LPMC_HW_STANDBY ##1 st_r.mode == LPMC_HIGH_SPEED);

endmodule : lpmc_ctrl

`default_nettype wire

// File: bench/lpmc_cpu_model.sv
// CPU side partner: sleep and wake pulses, reset and standby pins
`timescale 1ns/1ps
`default_nettype none
module lpmc_cpu_model #(
  parameter int SETTLE_CYC = 8                  // Oscillator settling, shortened
)(
  input  wire logic sys_clk_i,                  // System clock
  output logic      sleep_req_o,                // Sleep instruction pulse
  output logic      wake_irq_o,                 // Wake interrupt pulse
  output logic      reset_pin_n_o,              // Reset pin
  output logic      hardware_standby_pin_n_o    // Standby pin
);
  initial
  begin
    {sleep_req_o, wake_irq_o} = 2'h0;
    {reset_pin_n_o, hardware_standby_pin_n_o} = 2'h3;
  end
  task automatic pulse(input logic wake);
    @(posedge sys_clk_i);
    {wake_irq_o, sleep_req_o} <= {wake, ~wake};
    @(posedge sys_clk_i);
    {wake_irq_o, sleep_req_o} <= 2'h0;
  endtask : pulse
  // Pin stays low for the whole settling time
  task automatic reset_low();
    @(posedge sys_clk_i);
    reset_pin_n_o <= 1'b0;
    repeat (SETTLE_CYC) @(posedge sys_clk_i);
  endtask : reset_low
  task automatic reset_high();
    @(posedge sys_clk_i);
    reset_pin_n_o <= 1'b1;
  endtask : reset_high
  task automatic standby(input logic lvl);
    @(posedge sys_clk_i);
    hardware_standby_pin_n_o <= lvl;
  endtask : standby
endmodule : lpmc_cpu_model
`default_nettype wire

// File: bench/lpmc_ctrl_tb.sv
// Self-checking bench of the low power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmc_ctrl_tb;
  import lpmc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  wire logic   sleep_req, wake_irq, rst_pin_n, hardware_standby_pin_n_pin_n;
  logic [4:0]  mode;
  logic        clk_run, subclk, halt, rst_exc, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  p_stop, p_rst, mstop, mret;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int          bad_count = 0, comparisons = 0, cycles = 0, seed = 14449;
  // {wake, ctrl nibble, expected mode}
  logic [9:0]  steps [10] = '{{1'b0, 4'hb, 5'h01}, {1'b0, 4'hf, 5'h02}, {1'b0, 4'hd, 5'h04},
    {1'b1, 4'hd, 5'h02}, {1'b0, 4'hc, 5'h08}, {1'b1, 4'hc, 5'h02}, {1'b0, 4'h9, 5'h04},
    {1'b1, 4'h9, 5'h01}, {1'b0, 4'hf, 5'h02}, {1'b0, 4'hb, 5'h01}};
  always #12.5 sys_clk = ~sys_clk;

  lpmc_cpu_model CPU (.sys_clk_i(sys_clk), .sleep_req_o(sleep_req), .wake_irq_o(wake_irq),
    .reset_pin_n_o(rst_pin_n), .hardware_standby_pin_n_o(hardware_standby_pin_n_pin_n));
  lpmc_ctrl DUT (.sys_clk_i(sys_clk), .resetn_i(resetn), .sleep_req_i(sleep_req), .wake_irq_i(wake_irq),
    .reset_pin_n_i(rst_pin_n), .hardware_standby_pin_n_i(hardware_standby_pin_n_pin_n), .mode_o(mode),
    .sys_clk_run_o(clk_run), .cpu_subclock_o(subclk), .cpu_halt_o(halt), .reset_exception_o(rst_exc),
    .periph_stop_o(p_stop), .periph_reset_o(p_rst), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));

  // ==========================================================================
  // Reporting
  // ==========================================================================
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  // Run should end well below this
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  // Responses are matched in issue order, one transfer at a time
  always @(posedge sys_clk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      e = exp_q.pop_front();
      check("resp", {30'h0, bvalid ? bresp : rresp}, {30'h0, e[33:32]});
      if (rvalid)
        check("rdata", rdata, e[31:0]);
    end
  end

  // ==========================================================================
  // Bus master
  // ==========================================================================
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_q.push_back({er, 32'h0});
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do @(posedge sys_clk); while (!(awready && wready));
    {awvalid, wvalid} <= 2'h0;
    do @(posedge sys_clk); while (!bvalid);
    bready <= 1'b0;
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    exp_q.push_back({er, d});
    @(posedge sys_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge sys_clk); while (!rvalid);
    rready <= 1'b0;
  endtask : axr

  // ==========================================================================
  // Mode and peripheral expectations
  // ==========================================================================
  task automatic chk_mode(input logic [4:0] m);
    logic [7:0] st;
    st = (m == 5'h01) ? mstop : ((m == 5'h10) ? 8'hff : (8'hf0 | mstop));
    repeat (2) @(posedge sys_clk);
    #1;
    check("mode", {27'h0, mode}, {27'h0, m});
    check("clk_run", {31'h0, clk_run}, {31'h0, m == 5'h01});
    check("subclock", {31'h0, subclk}, {31'h0, m == 5'h02});
    check("halt", {31'h0, halt}, {31'h0, m[4:2] != 3'h0});
    check("stop", {24'h0, p_stop}, {24'h0, st});
    check("preset", {24'h0, p_rst}, {24'h0, (m == 5'h10) ? 8'hff : (st & ~mret)});
    axr(LPMC_OFS_STAT, {22'h0, hardware_standby_pin_n_pin_n, rst_pin_n, 3'h0, m}, LPMC_RESP_OKAY);
  endtask : chk_mode
  task automatic rst_cycle();
    logic seen_exc;
    seen_exc = 1'b0;
    CPU.reset_low();
    #1;
    check("clk_run", {31'h0, clk_run}, 32'h1);
    check("halt", {31'h0, halt}, 32'h1);
    check("stop", {24'h0, p_stop}, 32'hff);
    CPU.reset_high();
    repeat (8)
    begin
      @(posedge sys_clk);
      seen_exc = seen_exc | rst_exc;
    end
    check("exception", {31'h0, seen_exc}, 32'h1);
    mstop = 8'h00;
    mret = 8'h00;
    chk_mode(5'h01);
    axr(LPMC_OFS_CTRL, 32'h0, LPMC_RESP_OKAY);
  endtask : rst_cycle

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    mstop = 8'h00;
    mret = 8'h00;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    axr(LPMC_OFS_CTRL, 32'h0, LPMC_RESP_OKAY);
    axr(LPMC_OFS_MRET, 32'h0, LPMC_RESP_OKAY);
    axr(8'h10, 32'h0, LPMC_RESP_SLVERR);
    axw(8'h10, 32'hffff_ffff, LPMC_RESP_SLVERR);
    axw(LPMC_OFS_STAT, 32'hffff_ffff, LPMC_RESP_OKAY);
    chk_mode(5'h01);
    $display("test reset done");
    mstop = 8'($random(seed));
    mret = 8'($random(seed));
    axw(LPMC_OFS_MSTOP, {24'h0, mstop}, LPMC_RESP_OKAY);
    axw(LPMC_OFS_MRET, {24'h0, mret}, LPMC_RESP_OKAY);
    axr(LPMC_OFS_MSTOP, {24'h0, mstop}, LPMC_RESP_OKAY);
    chk_mode(5'h01);
    for (int i = 0; i < 10; i++)
    begin
      axw(LPMC_OFS_CTRL, {28'h0, steps[i][8:5]}, LPMC_RESP_OKAY);
      CPU.pulse(steps[i][9]);
      chk_mode(steps[i][4:0]);
    end
    $display("test transitions done");
    axw(LPMC_OFS_CTRL, 32'h0f, LPMC_RESP_OKAY);
    CPU.pulse(1'b0);
    chk_mode(5'h02);
    CPU.standby(1'b0);
    repeat (6) @(posedge sys_clk);
    chk_mode(5'h10);
    CPU.standby(1'b1);
    repeat (4) @(posedge sys_clk);
    chk_mode(5'h10);
    rst_cycle();
    $display("test standby done");
    axw(LPMC_OFS_CTRL, 32'h0f, LPMC_RESP_OKAY);
    CPU.pulse(1'b0);
    chk_mode(5'h02);
    rst_cycle();
    $display("test reset pin done");
    tally_and_finish();
  end
endmodule : lpmc_ctrl_tb
`default_nettype wire
